/* src/scms_params.svh */
// Functional notes
// - Startup clears inputs, presets outputs first
// - Startup queues interrupts for running mode
// - Output transfer enabled after startup sample
// - Scan order: outputs, inputs, execute, self-test
// - Inputs sampled in the input phase and at startup sample
// - Program writes only the output image
// - Running mode serves interrupts, traffic anytime
// - Per-module exclusion from automatic image update
// - Immediate read: live pin, image untouched
// - Immediate write: pin and image together
// - One of three modes, shown on indicators
// - Downloads accepted only while halted
// - Wipe clears memories, copies load; keeps diag
// - Running entered by warm restart, no wipe
// - Power-up enters configured mode
// - Power-up errors keep device out of running
// - Mode changes by panel, halt instruction, power-up or card removal
// - Halt instruction stops execution, enters halted
// - Retentive words saved on loss, restored later
// - Card insertion erases load memory and forces
// - Card removal forces halted mode
// - Date-time record used only as whole
`ifndef SCMS_PARAMS_SVH
`define SCMS_PARAMS_SVH
`define SCMS_PTS 16
`define SCMS_MODS 2
`define SCMS_MOD_PTS 8
`define SCMS_IDX_W 4
`define SCMS_MEM_WORDS 8
`define SCMS_MEM_AW 3
`define SCMS_WORD_W 8
`define SCMS_PEND_W 4
`define SCMS_PEND_MAX 4'hf
`define SCMS_PU_HALT 2'h0
`define SCMS_PU_RUN 2'h1
`define SCMS_PU_PREV 2'h2
`define SCMS_DTL_BYTES 12
`endif

/* src/scms_pkg.sv */
package scms_pkg;
    typedef enum logic [1:0] {MODE_HALTED, MODE_STARTUP, MODE_RUNNING} scms_mode_t;
    typedef enum logic [2:0] {PH_IDLE, PH_OUT, PH_IN, PH_EXEC, PH_TEST,
        SU_CLR, SU_ROUTINE, SU_SAMPLE} scms_phase_t;
    typedef enum logic [1:0] {WP_IDLE, WP_CLR, WP_COPY} scms_wipe_t;
    // Composite date-time record, twelve bytes, only moved as a whole
    typedef struct packed {
        logic [15:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [31:0] nanosecond;
    } scms_dtl_t;
endpackage

/* src/scms_seq.sv */
`timescale 1ns/10ps
`include "scms_params.svh"
module scms_seq
    import scms_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_powerup_mode,
    input wire logic i_saved_run,
    input wire logic i_diag_err,
    input wire logic i_panel_run,
    input wire logic i_panel_halt,
    input wire logic i_halt_instr,
    input wire logic i_exec_done,
    input wire logic [`SCMS_PTS-1:0] i_in_pins,
    input wire logic [`SCMS_PTS-1:0] i_subst_val,
    input wire logic i_keep_last,
    input wire logic [`SCMS_MODS-1:0] i_excl,
    input wire logic i_prog_wr,
    input wire logic [`SCMS_IDX_W-1:0] i_prog_idx,
    input wire logic i_prog_val,
    input wire logic [`SCMS_IDX_W-1:0] i_imm_rd_idx,
    input wire logic i_imm_wr,
    input wire logic [`SCMS_IDX_W-1:0] i_imm_wr_idx,
    input wire logic i_imm_wr_val,
    input wire logic i_irq,
    input wire logic i_comm_req,
    input wire logic i_dl_req,
    input wire logic [`SCMS_MEM_AW-1:0] i_dl_addr,
    input wire logic [`SCMS_WORD_W-1:0] i_dl_data,
    input wire logic i_wipe_cmd,
    input wire logic i_mem_wr,
    input wire logic i_mem_ret,
    input wire logic [`SCMS_MEM_AW-1:0] i_mem_addr,
    input wire logic [`SCMS_WORD_W-1:0] i_mem_data,
    input wire logic i_pwr_fail,
    input wire logic i_card_present,
    input wire logic i_force_wr,
    input wire logic [`SCMS_PTS-1:0] i_force_mask,
    input wire logic [`SCMS_PTS-1:0] i_force_val,
    input wire logic i_net_addr_wr,
    input wire logic [`SCMS_WORD_W-1:0] i_net_addr,
    input wire logic i_dtl_wr,
    input wire scms_dtl_t i_dtl,
    output logic o_mode_halted,
    output logic o_mode_startup,
    output logic o_mode_running,
    output logic o_startup_active,
    output logic o_exec_active,
    output logic o_selftest,
    output logic [`SCMS_PTS-1:0] o_out_pins,
    output logic [`SCMS_PTS-1:0] o_in_img,
    output logic [`SCMS_PTS-1:0] o_out_img,
    output logic o_out_en,
    output logic o_imm_rd_val,
    output logic o_irq_service,
    output logic [`SCMS_PEND_W-1:0] o_irq_pending,
    output logic o_comm_ack,
    output logic o_dl_ack,
    output logic o_dl_reject,
    output logic o_wipe_busy,
    output logic [`SCMS_WORD_W-1:0] o_mem_rd_work,
    output logic [`SCMS_WORD_W-1:0] o_mem_rd_ret,
    output logic [`SCMS_WORD_W-1:0] o_mem_rd_nonret,
    output logic [`SCMS_WORD_W-1:0] o_mem_rd_load,
    output logic o_diag_logged,
    output logic [`SCMS_WORD_W-1:0] o_net_addr,
    output scms_dtl_t o_dtl
);
    function automatic logic [`SCMS_PTS-1:0] excl_mask(input logic [`SCMS_MODS-1:0] e);
        excl_mask = {{`SCMS_MOD_PTS{e[1]}}, {`SCMS_MOD_PTS{e[0]}}};
    endfunction

    logic rst_s1_q, rst_n;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    scms_mode_t mode_q, mode_d;
    scms_phase_t ph_q, ph_d;
    scms_wipe_t wp_q;
    logic pwrup_q, halt_pend_q, run_pend_q, card_q, card_seen_q;
    logic [`SCMS_PTS-1:0] in_img_q, out_img_q, pins_q, frc_mask_q, frc_val_q;
    logic out_en_q, imm_rd_q, svc_q, comm_q, dl_ack_q, dl_rej_q, diag_q;
    logic [`SCMS_PEND_W-1:0] pend_q;
    logic [`SCMS_WORD_W-1:0] net_q;
    scms_dtl_t dtl_q;
    logic [`SCMS_WORD_W-1:0] work_m [`SCMS_MEM_WORDS];
    logic [`SCMS_WORD_W-1:0] ret_m [`SCMS_MEM_WORDS];
    logic [`SCMS_WORD_W-1:0] nonret_m [`SCMS_MEM_WORDS];
    logic [`SCMS_WORD_W-1:0] load_m [`SCMS_MEM_WORDS];
    // Backup copy has no reset: it models storage that outlives the power loss
    logic [`SCMS_WORD_W-1:0] ret_bk_m [`SCMS_MEM_WORDS];

    wire [`SCMS_PTS-1:0] xm = excl_mask(i_excl);
    wire running = (mode_q == MODE_RUNNING);
    wire halted = (mode_q == MODE_HALTED);
    wire card_insert = i_card_present && !card_q && card_seen_q;
    wire card_remove = !i_card_present && card_q;
    wire do_halt_instr = running && (ph_q == PH_EXEC) && i_halt_instr;
    wire scan_end = running && (ph_q == PH_TEST);
    wire su_start = (wp_q == WP_IDLE) && halted && !card_remove &&
        ((pwrup_q && !i_diag_err && (i_powerup_mode == `SCMS_PU_RUN ||
          (i_powerup_mode == `SCMS_PU_PREV && i_saved_run))) ||
         (!pwrup_q && run_pend_q));
    wire imm_wr_ok = running && i_imm_wr;
    wire [`SCMS_PTS-1:0] imm_bit = {{(`SCMS_PTS-1){1'b0}}, 1'b1} << i_imm_wr_idx;
    wire [`SCMS_PTS-1:0] prog_bit = {{(`SCMS_PTS-1){1'b0}}, 1'b1} << i_prog_idx;
    wire [`SCMS_PTS-1:0] init_val = i_keep_last ? pins_q : i_subst_val;
    wire [`SCMS_PTS-1:0] scan_out = (pins_q & xm) | (out_img_q & ~xm);
    wire prog_wr_ok = running && (ph_q == PH_EXEC) && i_prog_wr;

    always_comb begin
        mode_d = mode_q;
        ph_d = ph_q;
        case (mode_q)
            MODE_HALTED: begin
                if (su_start) begin
                    mode_d = MODE_STARTUP;
                    ph_d = SU_CLR;
                end
            end
            MODE_STARTUP: begin
                case (ph_q)
                    SU_CLR: ph_d = SU_ROUTINE;
                    SU_ROUTINE: if (i_exec_done) ph_d = SU_SAMPLE;
                    SU_SAMPLE: begin
                        mode_d = MODE_RUNNING;
                        ph_d = PH_OUT;
                    end
                    default: ph_d = SU_CLR;
                endcase
            end
            MODE_RUNNING: begin
                case (ph_q)
                    PH_OUT: ph_d = PH_IN;
                    PH_IN: ph_d = PH_EXEC;
                    PH_EXEC: if (i_exec_done) ph_d = PH_TEST;
                    PH_TEST: ph_d = PH_OUT;
                    default: ph_d = PH_OUT;
                endcase
                if (scan_end && halt_pend_q) begin
                    mode_d = MODE_HALTED;
                    ph_d = PH_IDLE;
                end
                if (do_halt_instr) begin
                    mode_d = MODE_HALTED;
                    ph_d = PH_IDLE;
                end
            end
            default: begin
                mode_d = MODE_HALTED;
                ph_d = PH_IDLE;
            end
        endcase
        if (card_remove) begin
            mode_d = MODE_HALTED;
            ph_d = PH_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_HALTED;
            ph_q <= PH_IDLE;
            pwrup_q <= 1'b1;
            halt_pend_q <= 1'b0;
            run_pend_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ph_q <= ph_d;
            pwrup_q <= 1'b0;
            // Only panel commands request changes; there is no local switch
            halt_pend_q <= (i_panel_halt && !halted) || (halt_pend_q && !halted);
            run_pend_q <= i_panel_run && halted && !su_start;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_img_q <= '0;
            out_img_q <= '0;
            pins_q <= '0;
            out_en_q <= 1'b0;
        end else begin
            if (mode_q == MODE_STARTUP && ph_q == SU_CLR) begin
                in_img_q <= '0;
                pins_q <= init_val;
                out_en_q <= 1'b0;
            end else if (mode_q == MODE_STARTUP && ph_q == SU_SAMPLE) begin
                in_img_q <= (in_img_q & xm) | (i_in_pins & ~xm);
                out_en_q <= 1'b1;
            end else if (running && ph_q == PH_OUT && out_en_q) begin
                pins_q <= scan_out;
            end else if (running && ph_q == PH_IN) begin
                in_img_q <= (in_img_q & xm) | (i_in_pins & ~xm);
            end
            if (prog_wr_ok) begin
                out_img_q <= i_prog_val ? (out_img_q | prog_bit) : (out_img_q & ~prog_bit);
            end
            if (imm_wr_ok) begin
                out_img_q <= i_imm_wr_val ? (out_img_q | imm_bit) : (out_img_q & ~imm_bit);
                pins_q <= i_imm_wr_val ? (pins_q | imm_bit) : (pins_q & ~imm_bit);
            end
            if (halted) begin
                out_en_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            imm_rd_q <= 1'b0;
            pend_q <= '0;
            svc_q <= 1'b0;
            comm_q <= 1'b0;
            dl_ack_q <= 1'b0;
            dl_rej_q <= 1'b0;
            card_q <= 1'b0;
            card_seen_q <= 1'b0;
            frc_mask_q <= '0;
            frc_val_q <= '0;
            diag_q <= 1'b0;
            net_q <= '0;
            dtl_q <= '0;
            wp_q <= WP_IDLE;
        end else begin
            imm_rd_q <= i_in_pins[i_imm_rd_idx];
            svc_q <= running && (i_irq || pend_q != '0);
            if (mode_q == MODE_STARTUP) begin
                if (i_irq && pend_q != `SCMS_PEND_MAX) begin
                    pend_q <= pend_q + 1'b1;
                end
            end else if (running && !i_irq && pend_q != '0) begin
                pend_q <= pend_q - 1'b1;
            end else if (halted) begin
                pend_q <= '0;
            end
            comm_q <= running && i_comm_req;
            dl_ack_q <= i_dl_req && halted;
            dl_rej_q <= i_dl_req && !halted;
            card_q <= i_card_present;
            card_seen_q <= 1'b1;
            if (card_insert) begin
                frc_mask_q <= '0;
            end else if (i_force_wr) begin
                frc_mask_q <= i_force_mask;
                frc_val_q <= i_force_val;
            end
            diag_q <= diag_q || (pwrup_q && i_diag_err);
            if (i_net_addr_wr) begin
                net_q <= i_net_addr;
            end
            if (i_dtl_wr) begin
                dtl_q <= i_dtl;
            end
            case (wp_q)
                WP_IDLE: if (i_wipe_cmd && halted) wp_q <= WP_CLR;
                WP_CLR: wp_q <= WP_COPY;
                WP_COPY: wp_q <= WP_IDLE;
                default: wp_q <= WP_IDLE;
            endcase
        end
    end

    // Memory arrays: plain storage, updated without reset so retention can be modelled
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < `SCMS_MEM_WORDS; i++) begin
            if (wp_q == WP_CLR) begin
                work_m[i] <= '0;
                ret_m[i] <= '0;
                nonret_m[i] <= '0;
            end else if (wp_q == WP_COPY) begin
                work_m[i] <= load_m[i];
            end else if (pwrup_q) begin
                ret_m[i] <= ret_bk_m[i];
            end else if (mode_q == MODE_STARTUP && ph_q == SU_CLR) begin
                nonret_m[i] <= '0;
            end
            if (card_insert) begin
                load_m[i] <= '0;
            end
            if (i_pwr_fail) begin
                ret_bk_m[i] <= ret_m[i];
            end
        end
        if (i_dl_req && halted && !card_insert) begin
            load_m[i_dl_addr] <= i_dl_data;
        end
        if (i_mem_wr && wp_q == WP_IDLE && !pwrup_q) begin
            if (i_mem_ret) begin
                ret_m[i_mem_addr] <= i_mem_data;
            end else begin
                nonret_m[i_mem_addr] <= i_mem_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_mem_rd_work <= '0;
            o_mem_rd_ret <= '0;
            o_mem_rd_nonret <= '0;
            o_mem_rd_load <= '0;
        end else begin
            o_mem_rd_work <= work_m[i_mem_addr];
            o_mem_rd_ret <= ret_m[i_mem_addr];
            o_mem_rd_nonret <= nonret_m[i_mem_addr];
            o_mem_rd_load <= load_m[i_mem_addr];
        end
    end

    assign o_mode_halted = halted;
    assign o_mode_startup = (mode_q == MODE_STARTUP);
    assign o_mode_running = running;
    assign o_startup_active = (mode_q == MODE_STARTUP) && (ph_q == SU_ROUTINE);
    assign o_exec_active = running && (ph_q == PH_EXEC);
    assign o_selftest = scan_end;
    assign o_out_pins = (pins_q & ~frc_mask_q) | (frc_val_q & frc_mask_q);
    assign o_in_img = in_img_q;
    assign o_out_img = out_img_q;
    assign o_out_en = out_en_q;
    assign o_imm_rd_val = imm_rd_q;
    assign o_irq_service = svc_q;
    assign o_irq_pending = pend_q;
    assign o_comm_ack = comm_q;
    assign o_dl_ack = dl_ack_q;
    assign o_dl_reject = dl_rej_q;
    assign o_wipe_busy = (wp_q != WP_IDLE);
    assign o_diag_logged = diag_q;
    assign o_net_addr = net_q;
    assign o_dtl = dtl_q;

    scan_order_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        running && ph_q == PH_OUT && !card_remove |=> ph_q == PH_IN ##1 ph_q == PH_EXEC || halted)
        else $error("scan phases out of order");
    startup_clear_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        mode_q == MODE_STARTUP && ph_q == SU_CLR |=> in_img_q == '0)
        else $error("input image not cleared in startup");
    irq_queue_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        mode_q == MODE_STARTUP |=> !svc_q)
        else $error("interrupt serviced during startup");
    out_enable_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        mode_q == MODE_STARTUP && ph_q != SU_SAMPLE |=> !out_en_q)
        else $error("output transfer enabled too early");
    img_stable_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_exec_active && $past(o_exec_active) |-> $stable(in_img_q))
        else $error("input image moved during execution");
    prog_write_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        prog_wr_ok && !imm_wr_ok |=> $stable(pins_q))
        else $error("program write reached pins");
    imm_read_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        1'b1 |=> imm_rd_q == $past(i_in_pins[i_imm_rd_idx]))
        else $error("immediate read not live");
    imm_write_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        imm_wr_ok |=> pins_q[$past(i_imm_wr_idx)] == $past(i_imm_wr_val)
            && out_img_q[$past(i_imm_wr_idx)] == $past(i_imm_wr_val))
        else $error("immediate write incomplete");
    one_mode_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        $onehot({o_mode_halted, o_mode_startup, o_mode_running}))
        else $error("mode indicators not one-hot");
    dl_reject_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_dl_req && !halted |=> dl_rej_q && !dl_ack_q)
        else $error("download not rejected");
    pwr_err_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        pwrup_q && i_diag_err |=> halted)
        else $error("left halted despite power-up error");
    card_halt_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        card_remove |=> halted)
        else $error("card removal did not halt");
    halt_instr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        do_halt_instr |=> halted && !o_exec_active)
        else $error("halt instruction ignored");
endmodule

/* testbench/scms_io_model.sv */
`timescale 1ns/10ps
module scms_io_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic i_halted,
    input wire logic i_dl_go,
    input wire logic i_dl_anyway,
    input wire logic [2:0] i_dl_addr,
    input wire logic [7:0] i_dl_data,
    output logic o_exec_done,
    output logic o_dl_req,
    output logic [2:0] o_dl_addr,
    output logic [7:0] o_dl_data
);
    logic [4:0] cnt_q;
    // A slow program holds the execute phase open
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 5'h00;
            o_exec_done <= 1'b0;
        end else if (!i_run || o_exec_done) begin
            cnt_q <= 5'h00;
            o_exec_done <= 1'b0;
        end else if (cnt_q == (i_slow ? 5'h14 : 5'h00)) begin
            o_exec_done <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    // Tool downloads only into a halted device unless a scenario insists
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dl_req <= 1'b0;
            o_dl_addr <= 3'h0;
            o_dl_data <= 8'h00;
        end else if (i_dl_go && (i_halted || i_dl_anyway) && !o_dl_req) begin
            o_dl_req <= 1'b1;
            o_dl_addr <= i_dl_addr;
            o_dl_data <= i_dl_data;
        end else if (o_dl_req) begin
            // Released lines do not keep the last word
            o_dl_req <= 1'b0;
            o_dl_addr <= ~o_dl_addr;
            o_dl_data <= ~o_dl_data;
        end
    end
endmodule

/* testbench/test_scan_cycle_mode_sequencer.sv */
`timescale 1ns/10ps
`include "scms_params.svh"
module test_scan_cycle_mode_sequencer
    import scms_pkg::*;
;
    logic i_clk, i_arst_n, i_saved_run, i_diag_err, i_panel_run, i_panel_halt, i_halt_instr;
    logic i_exec_done, i_keep_last, i_prog_wr, i_prog_val, i_imm_wr, i_imm_wr_val, i_irq;
    logic i_comm_req, i_dl_req, i_wipe_cmd, i_mem_wr, i_mem_ret, i_pwr_fail, i_card_present;
    logic i_force_wr, i_net_addr_wr, i_dtl_wr, slow, dl_go, dl_anyway;
    logic [1:0] i_powerup_mode, i_excl;
    logic [3:0] i_prog_idx, i_imm_rd_idx, i_imm_wr_idx, o_irq_pending;
    logic [2:0] i_dl_addr, i_mem_addr, dl_addr_t;
    logic [7:0] i_dl_data, i_mem_data, i_net_addr, dl_data_t, o_net_addr;
    logic [7:0] o_mem_rd_work, o_mem_rd_ret, o_mem_rd_nonret, o_mem_rd_load;
    logic [15:0] i_in_pins, i_subst_val, i_force_mask, i_force_val, o_out_pins, o_in_img, o_out_img;
    logic o_mode_halted, o_mode_startup, o_mode_running, o_startup_active, o_exec_active;
    logic o_selftest, o_out_en, o_imm_rd_val, o_irq_service, o_comm_ack, o_dl_ack, o_dl_reject;
    logic o_wipe_busy, o_diag_logged;
    scms_dtl_t i_dtl, o_dtl;
    int n_mismatch = 0;
    int total_checks = 0;

    scms_seq i_scms_seq (.i_clk, .i_arst_n, .i_powerup_mode, .i_saved_run, .i_diag_err,
        .i_panel_run, .i_panel_halt, .i_halt_instr, .i_exec_done, .i_in_pins, .i_subst_val,
        .i_keep_last, .i_excl, .i_prog_wr, .i_prog_idx, .i_prog_val, .i_imm_rd_idx, .i_imm_wr,
        .i_imm_wr_idx, .i_imm_wr_val, .i_irq, .i_comm_req, .i_dl_req, .i_dl_addr, .i_dl_data,
        .i_wipe_cmd, .i_mem_wr, .i_mem_ret, .i_mem_addr, .i_mem_data, .i_pwr_fail,
        .i_card_present, .i_force_wr, .i_force_mask, .i_force_val, .i_net_addr_wr, .i_net_addr,
        .i_dtl_wr, .i_dtl, .o_mode_halted, .o_mode_startup, .o_mode_running, .o_startup_active,
        .o_exec_active, .o_selftest, .o_out_pins, .o_in_img, .o_out_img, .o_out_en,
        .o_imm_rd_val, .o_irq_service, .o_irq_pending, .o_comm_ack, .o_dl_ack, .o_dl_reject,
        .o_wipe_busy, .o_mem_rd_work, .o_mem_rd_ret, .o_mem_rd_nonret, .o_mem_rd_load,
        .o_diag_logged, .o_net_addr, .o_dtl);

    scms_io_model i_scms_io_model (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_run(o_exec_active | o_startup_active), .i_slow(slow), .i_halted(o_mode_halted),
        .i_dl_go(dl_go), .i_dl_anyway(dl_anyway), .i_dl_addr(dl_addr_t), .i_dl_data(dl_data_t),
        .o_exec_done(i_exec_done), .o_dl_req(i_dl_req), .o_dl_addr(i_dl_addr),
        .o_dl_data(i_dl_data));

    always #2 i_clk = ~i_clk;

    task automatic step(input int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask

    // Bounded wait; a hang shows up as a mismatch instead of a stuck run
    task automatic wait_hi(ref logic s, input int lim, input string what);
        for (int k = 0; k < lim && s !== 1'b1; k++) step();
        chk(s, 1'b1, what);
    endtask

    task automatic do_reset(input logic [1:0] mode, input logic err);
        i_powerup_mode = mode;
        i_diag_err = err;
        i_arst_n = 1'b0;
        step(12);
        i_arst_n = 1'b1;
        step(3);
    endtask

    task automatic mem_write(input logic ret, input logic [7:0] d);
        i_mem_ret = ret;
        i_mem_data = d;
        i_mem_wr = 1'b1;
        step();
        i_mem_wr = 1'b0;
        step();
    endtask

    task automatic dl(input logic [2:0] a, input logic [7:0] d, input logic anyway);
        dl_addr_t = a;
        dl_data_t = d;
        dl_anyway = anyway;
        dl_go = 1'b1;
        step();
        dl_go = 1'b0;
        step();
    endtask

    task automatic enter_run(input logic keep);
        logic [15:0] p;
        p = o_out_pins;
        i_keep_last = keep;
        pulse(i_panel_run);
        wait_hi(o_mode_startup, 4, "startup entered");
        step();
        chk(o_in_img, 16'h0000, "input image cleared");
        chk(o_out_pins, keep ? p : i_subst_val, "outputs preset");
        chk({o_out_en, o_startup_active}, 2'h1, "transfer held off");
        pulse(i_irq);
        step();
        pulse(i_irq);
        step();
        chk({o_irq_pending, o_irq_service}, {4'h2, 1'b0}, "events queued");
        wait_hi(o_mode_running, 40, "running reached");
        chk(o_out_en, 1'b1, "transfer enabled");
        chk(o_mem_rd_nonret, 8'h00, "warm restart cleared");
        step(3);
        chk(o_irq_pending, 4'h0, "queue drained");
    endtask

    task automatic t_powerup();
        do_reset(`SCMS_PU_HALT, 1'b0);
        chk({o_mode_halted, o_mode_startup, o_mode_running}, 3'h4, "one mode");
        step(4);
        chk(o_mode_halted, 1'b1, "stays halted");
        mem_write(1'b1, 8'ha5);
        i_pwr_fail = 1'b1;
        step(2);
        i_pwr_fail = 1'b0;
        do_reset(`SCMS_PU_RUN, 1'b1);
        step(6);
        chk({o_mode_halted, o_diag_logged}, 2'h3, "error blocks run");
        chk(o_mem_rd_ret, 8'ha5, "retained word back");
        i_dtl = 96'h07e9_0c_1f_03_17_3b_3b_0001e240;
        pulse(i_dtl_wr);
        step();
        chk(o_dtl, i_dtl, "date record whole");
        do_reset(`SCMS_PU_RUN, 1'b0);
        wait_hi(o_mode_startup, 4, "configured run");
        i_saved_run = 1'b1;
        do_reset(`SCMS_PU_PREV, 1'b0);
        wait_hi(o_mode_startup, 4, "previous mode");
        do_reset(`SCMS_PU_HALT, 1'b0);
    endtask

    task automatic t_memory();
        dl(3'h3, 8'h5a, 1'b0);
        chk(o_dl_ack, 1'b1, "download taken");
        mem_write(1'b1, 8'ha5);
        mem_write(1'b0, 8'h3c);
        i_net_addr = 8'h3c;
        pulse(i_net_addr_wr);
        chk(o_mem_rd_ret, 8'ha5, "retentive written");
        pulse(i_wipe_cmd);
        chk(o_wipe_busy, 1'b1, "wipe clear");
        step();
        chk(o_wipe_busy, 1'b1, "wipe copy");
        step();
        chk(o_wipe_busy, 1'b0, "wipe over");
        step();
        chk({o_mem_rd_work, o_mem_rd_ret, o_mem_rd_nonret}, 24'h5a0000, "wipe result");
        chk({o_mem_rd_load, o_net_addr}, 16'h5a3c, "wipe keeps");
        mem_write(1'b0, 8'h3c);
    endtask

    task automatic t_scan();
        logic v;
        logic v2;
        enter_run(1'b0);
        i_in_pins = 16'h00a5;
        wait_hi(o_selftest, 60, "scan end");
        step(2);
        chk(o_exec_active, 1'b0, "no run before inputs");
        step();
        chk(o_exec_active, 1'b1, "run after out and in");
        chk(o_in_img, 16'h00a5, "inputs sampled");
        i_in_pins = 16'hff5a;
        step(3);
        chk(o_in_img, 16'h00a5, "image steady");
        v = ~o_out_pins[4];
        i_prog_idx = 4'h4;
        i_prog_val = v;
        pulse(i_prog_wr);
        chk({o_out_img[4], o_out_pins[4]}, {v, ~v}, "image only");
        i_imm_rd_idx = 4'h8;
        step();
        chk(o_imm_rd_val, 1'b1, "live pin read");
        v2 = ~o_out_pins[9];
        i_imm_wr_idx = 4'h9;
        i_imm_wr_val = v2;
        pulse(i_imm_wr);
        chk({o_out_pins[9], o_out_img[9]}, {v2, v2}, "direct write");
        pulse(i_irq);
        chk(o_irq_service, 1'b1, "event served");
        pulse(i_comm_req);
        chk(o_comm_ack, 1'b1, "traffic served");
        dl(3'h1, 8'h77, 1'b1);
        chk({o_dl_reject, o_dl_ack}, 2'h2, "download refused");
        i_excl = 2'h2;
        i_in_pins = 16'h3355;
        wait_hi(o_selftest, 40, "scan end");
        step(2);
        chk({o_out_pins[4], o_in_img}, {v, 16'h00a5}, "outputs first");
        step();
        chk(o_in_img, 16'h0055, "module excluded");
        i_excl = 2'h0;
    endtask

    task automatic t_halt();
        wait_hi(o_exec_active, 60, "execute phase");
        pulse(i_panel_halt);
        step(2);
        chk(o_mode_running, 1'b1, "halt deferred");
        wait_hi(o_selftest, 40, "scan end");
        wait_hi(o_mode_halted, 3, "halt at boundary");
        enter_run(1'b1);
        wait_hi(o_exec_active, 60, "execute phase");
        pulse(i_halt_instr);
        chk({o_mode_halted, o_exec_active}, 2'h2, "halt instruction");
        dl(3'h3, 8'h66, 1'b0);
        enter_run(1'b0);
        slow = 1'b0;
        {i_force_mask, i_force_val} = '1;
        pulse(i_force_wr);
        step(5);
        i_card_present = 1'b0;
        step();
        chk(o_mode_halted, 1'b1, "card pulled");
        i_card_present = 1'b1;
        step(3);
        chk({o_mem_rd_load, o_out_pins}, 24'h000210, "card wipes load");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        i_arst_n = 1'b0;
        {i_saved_run, i_diag_err, i_panel_run, i_panel_halt, i_halt_instr, i_keep_last} = '0;
        {i_prog_wr, i_prog_val, i_imm_wr, i_imm_wr_val, i_irq, i_comm_req, i_wipe_cmd} = '0;
        {i_mem_wr, i_mem_ret, i_pwr_fail, i_force_wr, i_net_addr_wr, i_dtl_wr} = '0;
        {dl_go, dl_anyway, dl_addr_t, dl_data_t, i_powerup_mode, i_excl} = '0;
        {i_prog_idx, i_imm_rd_idx, i_imm_wr_idx, i_mem_data, i_net_addr} = '0;
        {i_in_pins, i_force_mask, i_force_val, i_dtl} = '0;
        i_mem_addr = 3'h3;
        i_subst_val = 16'h0f0f;
        i_card_present = 1'b1;
        slow = 1'b1;
        t_powerup();
        t_memory();
        t_scan();
        t_halt();
        conclude();
    end

    // Sequence needs a few hundred cycles
    initial begin
        #80000;
        n_mismatch++;
        conclude();
    end
endmodule
